//--- logic/ifeb_pkg.sv
// package: register map, bit layouts and carrier types of the interrupt flag/enable bank
package ifeb_pkg;

  // ------------------------------------------------------------
  // register byte addresses (word aligned, 32-bit Avalon words)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS_B    = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_C    = 8'h04;
  localparam logic [7:0] ADDR_ENABLE_A   = 8'h08;
  localparam logic [7:0] ADDR_ENABLE_B   = 8'h0C;
  localparam logic [7:0] ADDR_ENABLE_D   = 8'h10;
  localparam logic [7:0] ADDR_ENABLE_E   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;

  // ------------------------------------------------------------
  // implemented bits of each 16-bit register
  // ------------------------------------------------------------
  // flags_b: 15 pair1 done, 14 pair0 done, 7 comparator2, 1 pwm gen4
  localparam logic [15:0] FLAGS_B_MASK  = 16'hC082;
  // flags_c: 4 pair6 done, 1 pair3 done, 0 pair2 done
  localparam logic [15:0] FLAGS_C_MASK  = 16'h0013;
  // enable_a: 13 adc, 12 uart tx, 11 uart rx, 10 spi, 9 spi error,
  // 7 timer b, 3 timer a, 2 out compare, 1 in capture, 0 ext irq0
  localparam logic [15:0] ENABLE_A_MASK = 16'h3E8F;
  // enable_b: 13 ext irq2, 4 ext irq1, 3 change notify, 2 comparator1,
  // 1 i2c master, 0 i2c slave
  localparam logic [15:0] ENABLE_B_MASK = 16'h201F;
  // enable_d: 9 pwm special match
  localparam logic [15:0] ENABLE_D_MASK = 16'h0200;
  // enable_e: 1 uart error
  localparam logic [15:0] ENABLE_E_MASK = 16'h0002;

  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam int          REG_W         = 16;
  localparam int          IRQ_W         = 6;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

  // interrupt status bit per register group
  localparam int IRQ_FLAGS_B  = 0;
  localparam int IRQ_FLAGS_C  = 1;
  localparam int IRQ_ENABLE_A = 2;
  localparam int IRQ_ENABLE_B = 3;
  localparam int IRQ_ENABLE_D = 4;
  localparam int IRQ_ENABLE_E = 5;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  // one-cycle set pulses from the sources whose flags live here
  typedef struct packed {
    logic [15:0] flags_b_set;
    logic [15:0] flags_c_set;
  } ifeb_evt_t;

  // levels held elsewhere in the controller
  typedef struct packed {
    logic [15:0] enable_b_lvl;  // enables for the flags_b sources
    logic [15:0] enable_c_lvl;  // enables for the flags_c sources
    logic [15:0] flag_a_lvl;    // flags for the enable_a sources
    logic [15:0] flag_b_lvl;
    logic [15:0] flag_d_lvl;
    logic [15:0] flag_e_lvl;
  } ifeb_ext_t;

  // gated requests to the cpu, one vector per register
  typedef struct packed {
    logic [15:0] flags_b;
    logic [15:0] flags_c;
    logic [15:0] enable_a;
    logic [15:0] enable_b;
    logic [15:0] enable_d;
    logic [15:0] enable_e;
  } ifeb_req_t;

endpackage : ifeb_pkg

//--- logic/ifeb_top.sv
// module: interrupt flag and enable bank with Avalon-MM register access
`timescale 1ns/1ns
// Summary of operation
// - flag bits set by source, software read/write
// - enable bit one passes request, zero blocks
// - unimplemented bits read zero, ignore writes
// - all flag and enable bits reset zero
// - flags_b bits 15,14,7,1 hold sources
// - flags_c bits 4,1,0 hold adc pairs
// - enable_a bits 13 to 9 enable sources
// - enable_a bits 7,3,2,1,0 enable sources
// - enable_b bits 13,4,3,2,1,0 enable sources
// - enable_d bit 9 enables pwm special match
// - enable_e bit 1 enables uart error
// - absent peripherals leave bits unimplemented
module ifeb_top #(
  parameter logic [15:0] FLAGS_B_IMPL  = ifeb_pkg::FLAGS_B_MASK,
  parameter logic [15:0] FLAGS_C_IMPL  = ifeb_pkg::FLAGS_C_MASK,
  parameter logic [15:0] ENABLE_A_IMPL = ifeb_pkg::ENABLE_A_MASK,
  parameter logic [15:0] ENABLE_B_IMPL = ifeb_pkg::ENABLE_B_MASK,
  parameter logic [15:0] ENABLE_D_IMPL = ifeb_pkg::ENABLE_D_MASK,
  parameter logic [15:0] ENABLE_E_IMPL = ifeb_pkg::ENABLE_E_MASK
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire ifeb_pkg::ifeb_evt_t evt,
  input  wire ifeb_pkg::ifeb_ext_t ext,
  output ifeb_pkg::ifeb_req_t     req,
  output logic                    irq
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // a variant may drop bits but never add positions that do not exist
  if ((FLAGS_B_IMPL & ~ifeb_pkg::FLAGS_B_MASK) != 16'h0000 ||
      (FLAGS_C_IMPL & ~ifeb_pkg::FLAGS_C_MASK) != 16'h0000 ||
      (ENABLE_A_IMPL & ~ifeb_pkg::ENABLE_A_MASK) != 16'h0000 ||
      (ENABLE_B_IMPL & ~ifeb_pkg::ENABLE_B_MASK) != 16'h0000 ||
      (ENABLE_D_IMPL & ~ifeb_pkg::ENABLE_D_MASK) != 16'h0000 ||
      (ENABLE_E_IMPL & ~ifeb_pkg::ENABLE_E_MASK) != 16'h0000)
  begin : g_bad_mask
    $error("implemented-bit mask exceeds the documented layout");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // merge the low two byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
    logic [15:0] v;
    v = old_v;
    if (be[0])
    begin
      v[7:0] = wdata[7:0];
    end
    if (be[1])
    begin
      v[15:8] = wdata[15:8];
    end
    return v;
  endfunction : lane_merge

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc_wr;
  logic        acc_rd;

  // a request is taken at the edge where waitrequest is seen low
  assign acc_wr = avs_write && !wait_q;
  assign acc_rd = avs_read && !wait_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
    end
    else if (!wait_q)
    begin
      wait_q <= 1'b1;
    end
    else if (avs_read || avs_write)
    begin
      wait_q <= 1'b0;
    end
  end

  logic wr_flags_b;
  logic wr_flags_c;
  logic wr_en_a;
  logic wr_en_b;
  logic wr_en_d;
  logic wr_en_e;
  logic wr_irq_clr;
  logic wr_irq_en;

  assign wr_flags_b = acc_wr && avs_address == ifeb_pkg::ADDR_FLAGS_B;
  assign wr_flags_c = acc_wr && avs_address == ifeb_pkg::ADDR_FLAGS_C;
  assign wr_en_a    = acc_wr && avs_address == ifeb_pkg::ADDR_ENABLE_A;
  assign wr_en_b    = acc_wr && avs_address == ifeb_pkg::ADDR_ENABLE_B;
  assign wr_en_d    = acc_wr && avs_address == ifeb_pkg::ADDR_ENABLE_D;
  assign wr_en_e    = acc_wr && avs_address == ifeb_pkg::ADDR_ENABLE_E;
  assign wr_irq_clr = acc_wr && avs_address == ifeb_pkg::ADDR_IRQ_CLEAR;
  assign wr_irq_en  = acc_wr && avs_address == ifeb_pkg::ADDR_IRQ_ENABLE;

  // ------------------------------------------------------------
  // flag registers
  // ------------------------------------------------------------
  logic [15:0] flags_b_q;
  logic [15:0] flags_b_d;
  logic [15:0] flags_c_q;
  logic [15:0] flags_c_d;

  // a source pulse in the same cycle as a software write still sets
  always_comb
  begin
    flags_b_d = wr_flags_b ? lane_merge(flags_b_q, avs_writedata, avs_byteenable)
                           : flags_b_q;
    flags_b_d = (flags_b_d | evt.flags_b_set) & FLAGS_B_IMPL;
    flags_c_d = wr_flags_c ? lane_merge(flags_c_q, avs_writedata, avs_byteenable)
                           : flags_c_q;
    flags_c_d = (flags_c_d | evt.flags_c_set) & FLAGS_C_IMPL;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_b_q <= ifeb_pkg::REG_RESET;
      flags_c_q <= ifeb_pkg::REG_RESET;
    end
    else
    begin
      flags_b_q <= flags_b_d;
      flags_c_q <= flags_c_d;
    end
  end

  // ------------------------------------------------------------
  // enable registers
  // ------------------------------------------------------------
  logic [15:0] en_a_q;
  logic [15:0] en_b_q;
  logic [15:0] en_d_q;
  logic [15:0] en_e_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_a_q <= ifeb_pkg::REG_RESET;
      en_b_q <= ifeb_pkg::REG_RESET;
      en_d_q <= ifeb_pkg::REG_RESET;
      en_e_q <= ifeb_pkg::REG_RESET;
    end
    else
    begin
      // absent variant bits stay zero through the mask
      if (wr_en_a)
      begin
        en_a_q <= lane_merge(en_a_q, avs_writedata, avs_byteenable) & ENABLE_A_IMPL;
      end
      if (wr_en_b)
      begin
        en_b_q <= lane_merge(en_b_q, avs_writedata, avs_byteenable) & ENABLE_B_IMPL;
      end
      if (wr_en_d)
      begin
        en_d_q <= lane_merge(en_d_q, avs_writedata, avs_byteenable) & ENABLE_D_IMPL;
      end
      if (wr_en_e)
      begin
        en_e_q <= lane_merge(en_e_q, avs_writedata, avs_byteenable) & ENABLE_E_IMPL;
      end
    end
  end

  // ------------------------------------------------------------
  // gated requests
  // ------------------------------------------------------------
  ifeb_pkg::ifeb_req_t req_d;

  always_comb
  begin
    req_d.flags_b  = flags_b_d & ext.enable_b_lvl & FLAGS_B_IMPL;
    req_d.flags_c  = flags_c_d & ext.enable_c_lvl & FLAGS_C_IMPL;
    req_d.enable_a = ext.flag_a_lvl & en_a_q;
    req_d.enable_b = ext.flag_b_lvl & en_b_q;
    req_d.enable_d = ext.flag_d_lvl & en_d_q;
    req_d.enable_e = ext.flag_e_lvl & en_e_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req <= '0;
    end
    else
    begin
      req <= req_d;
    end
  end

  // ------------------------------------------------------------
  // interrupt status, clear and enable
  // ------------------------------------------------------------
  logic [ifeb_pkg::IRQ_W-1:0] grp_d;
  logic [ifeb_pkg::IRQ_W-1:0] grp_q;
  logic [ifeb_pkg::IRQ_W-1:0] stat_q;
  logic [ifeb_pkg::IRQ_W-1:0] stat_d;
  logic [ifeb_pkg::IRQ_W-1:0] irq_en_q;
  logic [ifeb_pkg::IRQ_W-1:0] clr;

  always_comb
  begin
    grp_d[ifeb_pkg::IRQ_FLAGS_B]  = |req_d.flags_b;
    grp_d[ifeb_pkg::IRQ_FLAGS_C]  = |req_d.flags_c;
    grp_d[ifeb_pkg::IRQ_ENABLE_A] = |req_d.enable_a;
    grp_d[ifeb_pkg::IRQ_ENABLE_B] = |req_d.enable_b;
    grp_d[ifeb_pkg::IRQ_ENABLE_D] = |req_d.enable_d;
    grp_d[ifeb_pkg::IRQ_ENABLE_E] = |req_d.enable_e;
    clr = wr_irq_clr ? avs_writedata[ifeb_pkg::IRQ_W-1:0] : ifeb_pkg::IRQ_RESET;
    // a new request rising in the clear cycle wins
    stat_d = (stat_q & ~clr) | (grp_d & ~grp_q);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grp_q    <= ifeb_pkg::IRQ_RESET;
      stat_q   <= ifeb_pkg::IRQ_RESET;
      irq_en_q <= ifeb_pkg::IRQ_RESET;
      irq      <= 1'b0;
    end
    else
    begin
      grp_q  <= grp_d;
      stat_q <= stat_d;
      if (wr_irq_en && avs_byteenable[0])
      begin
        irq_en_q <= avs_writedata[ifeb_pkg::IRQ_W-1:0];
      end
      irq <= |(stat_d & (wr_irq_en && avs_byteenable[0]
                         ? avs_writedata[ifeb_pkg::IRQ_W-1:0] : irq_en_q));
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] rmux;

  // unimplemented positions and unmapped words read as zero
  always_comb
  begin
    rmux = 32'h0000_0000;
    unique case (avs_address)
      ifeb_pkg::ADDR_FLAGS_B:    rmux[15:0] = flags_b_q;
      ifeb_pkg::ADDR_FLAGS_C:    rmux[15:0] = flags_c_q;
      ifeb_pkg::ADDR_ENABLE_A:   rmux[15:0] = en_a_q;
      ifeb_pkg::ADDR_ENABLE_B:   rmux[15:0] = en_b_q;
      ifeb_pkg::ADDR_ENABLE_D:   rmux[15:0] = en_d_q;
      ifeb_pkg::ADDR_ENABLE_E:   rmux[15:0] = en_e_q;
      ifeb_pkg::ADDR_IRQ_STATUS: rmux[ifeb_pkg::IRQ_W-1:0] = stat_q;
      ifeb_pkg::ADDR_IRQ_ENABLE: rmux[ifeb_pkg::IRQ_W-1:0] = irq_en_q;
      default:                   rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (avs_read && wait_q)
    begin
      rdata_q <= rmux;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule : ifeb_top

//--- test/ifeb_assertions.sv
// checker: bus timing and request gating seen at the bank's ports
`timescale 1ns/1ns
module ifeb_assertions #(
  parameter logic [15:0] FLAGS_B_IMPL  = ifeb_pkg::FLAGS_B_MASK,
  parameter logic [15:0] FLAGS_C_IMPL  = ifeb_pkg::FLAGS_C_MASK,
  parameter logic [15:0] ENABLE_A_IMPL = ifeb_pkg::ENABLE_A_MASK
) (
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire ifeb_pkg::ifeb_evt_t evt,
  input wire ifeb_pkg::ifeb_ext_t ext,
  input wire ifeb_pkg::ifeb_req_t req,
  input wire logic                irq
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  logic [15:0] fire_b;
  assign fire_b = evt.flags_b_set & ext.enable_b_lvl & FLAGS_B_IMPL;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  reset_values_a: assert property (
    $rose(rst_n) |-> avs_waitrequest && !irq && req == '0 && avs_readdata == 32'h0)
    else $error("outputs not clear after reset");
  answer_latency_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  answer_cause_a: assert property (
    !avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("answer with no request before");
  readdata_upper_a: assert property (
    !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  req_gate_a: assert property (
    ((req.flags_b & ~$past(ext.enable_b_lvl)) | (req.flags_c & ~$past(ext.enable_c_lvl))
     | (req.enable_a & ~$past(ext.flag_a_lvl))) == 16'h0000)
    else $error("request without enable or flag");
  req_unimpl_a: assert property (
    ((req.flags_b & ~FLAGS_B_IMPL) | (req.flags_c & ~FLAGS_C_IMPL)
     | (req.enable_a & ~ENABLE_A_IMPL)) == 16'h0000)
    else $error("request on unimplemented bit");
  set_to_req_a: assert property (
    fire_b != 16'h0000 |=> (req.flags_b & $past(fire_b)) == $past(fire_b))
    else $error("source set did not raise request");
  far_gate_a: assert property (
    ((req.enable_b & ~$past(ext.flag_b_lvl)) | (req.enable_d & ~$past(ext.flag_d_lvl))
     | (req.enable_e & ~$past(ext.flag_e_lvl))) == 16'h0000)
    else $error("enable request without source flag");
  irq_cause_a: assert property (
    $rose(irq) |-> req != '0 || ($past(avs_write) && !$past(avs_waitrequest)))
    else $error("interrupt rose with no request or enable write");
endmodule : ifeb_assertions

bind ifeb_top ifeb_assertions #(
  .FLAGS_B_IMPL(FLAGS_B_IMPL), .FLAGS_C_IMPL(FLAGS_C_IMPL), .ENABLE_A_IMPL(ENABLE_A_IMPL)
) ifeb_assertions_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt), .ext(ext),
  .req(req), .irq(irq)
);

//--- test/ifeb_source_model.sv
// partner model: event sources and the levels held elsewhere in the controller
`timescale 1ns/1ns
module ifeb_source_model (
  input wire logic            sys_clk,
  output ifeb_pkg::ifeb_evt_t evt,
  output ifeb_pkg::ifeb_ext_t ext
);
  initial
  begin
    evt = '0;
    ext = '0;
  end
  // one-cycle set pulse from the sources
  task automatic pulse(input ifeb_pkg::ifeb_evt_t v);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= '0;
  endtask : pulse
  task automatic levels(input ifeb_pkg::ifeb_ext_t v);
    @(posedge sys_clk);
    ext <= v;
  endtask : levels
endmodule : ifeb_source_model

//--- test/interrupt_flag_enable_bank_bench.sv
// testbench: register access, source flags, request gating and interrupt
`timescale 1ns/1ns
module interrupt_flag_enable_bank_bench;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [7:0]          avs_address = 8'h00;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = 32'h0;
  logic [3:0]          avs_byteenable = 4'h3;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  ifeb_pkg::ifeb_evt_t evt;
  ifeb_pkg::ifeb_ext_t ext;
  ifeb_pkg::ifeb_ext_t e;
  ifeb_pkg::ifeb_req_t req;
  logic                irq;
  logic [31:0]         rd;
  int                  n_fail = 0;
  int                  checks_done = 0;
  int                  cyc = 0;
  logic [7:0]  addr_t [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] mask_t [6] = '{16'hC082, 16'h0013, 16'h3E8F, 16'h201F, 16'h0200, 16'h0002};
  localparam logic [95:0] ALL_M = {16'hC082, 16'h0013, 16'h3E8F, 16'h201F, 16'h0200, 16'h0002};

  always #5 sys_clk = ~sys_clk;

  ifeb_top ifeb_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt), .ext(ext),
    .req(req), .irq(irq)
  );
  ifeb_source_model ifeb_source_model_i (.sys_clk(sys_clk), .evt(evt), .ext(ext));

  // ------------------------------------------------------------
  // bus cycle, compare and verdict
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, addr_t[i], 32'h0);
      chk(rd, 96'h0);
      bus(1'b1, addr_t[i], 32'hFFFF_FFFF);
      bus(1'b0, addr_t[i], 32'h0);
      chk(rd, {80'h0, mask_t[i]});
      bus(1'b1, addr_t[i], 32'h0);
      bus(1'b0, addr_t[i], 32'h0);
      chk(rd, 96'h0);
    end
    avs_byteenable <= 4'h2;
    bus(1'b1, ifeb_pkg::ADDR_ENABLE_B, 32'hFFFF_FFFF);
    avs_byteenable <= 4'h3;
    bus(1'b0, ifeb_pkg::ADDR_ENABLE_B, 32'h0);
    chk(rd, 96'h2000);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 96'h0);
    ifeb_source_model_i.pulse({16'hFFFF, 16'hFFFF});
    bus(1'b0, ifeb_pkg::ADDR_FLAGS_B, 32'h0);
    chk(rd, 96'hC082);
    bus(1'b0, ifeb_pkg::ADDR_FLAGS_C, 32'h0);
    chk(rd, 96'h0013);
    chk(req, 96'h0);
    ifeb_source_model_i.levels('1);
    for (int i = 2; i < 6; i++) bus(1'b1, addr_t[i], 32'hFFFF);
    repeat (3) @(posedge sys_clk);
    chk(req, ALL_M);
    ifeb_source_model_i.levels('0);
    repeat (3) @(posedge sys_clk);
    chk(req, 96'h0);
    bus(1'b1, ifeb_pkg::ADDR_FLAGS_B, 32'h0);
    bus(1'b1, ifeb_pkg::ADDR_IRQ_ENABLE, 32'h0);
    bus(1'b1, ifeb_pkg::ADDR_IRQ_CLEAR, 32'h3F);
    bus(1'b0, ifeb_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 96'h0);
    e = '0;
    e.enable_b_lvl = 16'h8000;
    ifeb_source_model_i.levels(e);
    ifeb_source_model_i.pulse({16'h8000, 16'h0000});
    repeat (2) @(posedge sys_clk);
    chk(req, {16'h8000, 80'h0});
    chk(irq, 96'h0);
    bus(1'b0, ifeb_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 96'h01);
    bus(1'b1, ifeb_pkg::ADDR_IRQ_ENABLE, 32'h01);
    repeat (2) @(posedge sys_clk);
    chk(irq, 96'h1);
    bus(1'b1, ifeb_pkg::ADDR_FLAGS_B, 32'h0);
    bus(1'b1, ifeb_pkg::ADDR_IRQ_CLEAR, 32'h01);
    repeat (2) @(posedge sys_clk);
    chk(irq, 96'h0);
    chk(req, 96'h0);
    report_and_stop();
  end
endmodule : interrupt_flag_enable_bank_bench
